// ### hdl/wdp_pkg.sv
// What this block does
// R1: The watchdog counter advances only on edges of its own free-running RC oscillator pin.
// R2: The watchdog keeps counting while the main clock is stopped, including during sleep.
// R3: An expiry while awake requests a full device reset and records it as a watchdog reset.
// R4: An expiry while asleep wakes the device without reset and records it as a wake-up.
// R5: Every expiry clears the watchdog expiry flag.
// R6: A zero in the watchdog enable fuse of the configuration word disables the watchdog for good.
// R7: One scaler is shared between Timer0 and the watchdog, routed and ratioed by the option register.
// R8: The clear and sleep instructions restart the counter, and the scaler when it serves the watchdog.
// R9: A clear instruction zeroes the scaler count when the scaler serves the watchdog, and leaves the scaler assignment untouched.
// R10: A set assignment select routes the scaler to the watchdog, dividing expiry by two to the ratio.
package wdp_pkg;

    // Register indices; a byte address is four times the index.
    localparam logic [15:0] OPT_IDX   = 16'h0081;
    localparam logic [15:0] CFG_IDX   = 16'h2007;
    localparam logic [15:0] STAT_IDX  = 16'h0090;
    localparam logic [15:0] MASK_IDX  = 16'h0091;
    localparam logic [15:0] STATE_IDX = 16'h0092;
    localparam int          ADDR_W    = 16;
    localparam int          IDX_LSB   = 2;

    // Option register layout and reset value.
    localparam int          OPT_W       = 8;
    localparam int          OPT_PSA_BIT = 3;
    localparam int          OPT_PS_LSB  = 0;
    localparam int          PS_W        = 3;
    localparam logic [7:0]  OPT_RESET   = 8'hFF;

    // Configuration word layout.
    localparam int          CFG_W        = 14;
    localparam int          CFG_WATCHDOG_ENABLE_FUSE_BIT = 2;

    // Event status and mask layout.
    localparam int          EV_W      = 2;
    localparam int          EV_RST    = 0;
    localparam int          EV_WAKE   = 1;
    localparam logic [1:0]  EV_RESET  = 2'h0;

    // State register layout.
    localparam int          ST_TO    = 0;
    localparam int          ST_SLEEP = 1;
    localparam int          ST_EN    = 2;

    // Scaler shift width covers ratios up to 2 to the 8th.
    localparam int          SHIFT_W = 4;

    typedef enum logic {
        WDP_RUN,
        WDP_SLEEP
    } wdp_mode_t;

endpackage

// ### hdl/wdp_scaler.sv
`timescale 1ns/1ns
// Power-of-two divider of a tick stream; output is a registered one-cycle pulse.
module wdp_scaler #(
    parameter int CNT_W = 8
) (
    // Clock and reset.
    input  wire logic                        core_clk,
    input  wire logic                        resetn,
    // Control.
    input  wire logic                        clr,
    input  wire logic [wdp_pkg::SHIFT_W-1:0] shift,
    // Ticks.
    input  wire logic                        tick_in,
    output logic                             tick_out
);

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [CNT_W-1:0] term;
    logic             hit;
    logic             out_q;

    // Terminal count is two to the shift, less one.
    // At-or-above, so a ratio lowered mid-count ends the period at once instead of wrapping.
    assign term  = CNT_W'((CNT_W+1)'(1) << shift) - CNT_W'(1);
    assign hit   = tick_in && (cnt_q >= term);
    assign cnt_d = hit ? '0 : cnt_q + CNT_W'(1);

    // Clear wins over an arriving tick so a restart never leaks a pulse.
    always_ff @(posedge core_clk) begin
        if (!resetn || clr) begin
            cnt_q <= '0;
            out_q <= 1'b0;
        end else begin
            out_q <= hit;
            if (tick_in) begin
                cnt_q <= cnt_d;
            end
        end
    end

    assign tick_out = out_q;

endmodule

// ### hdl/wdp_watchdog.sv
`timescale 1ns/1ns
// Watchdog with shared postscaler, run from core_clk with the RC oscillator as a sampled pin.
module wdp_watchdog #(
    parameter int BASE_W  = 8,
    parameter int SCALE_W = 8,
    parameter logic [wdp_pkg::OPT_W-1:0] OPT_INIT = wdp_pkg::OPT_RESET
) (
    // Clock and reset.
    input  wire logic                      core_clk,
    input  wire logic                      resetn,
    // Avalon-MM slave.
    input  wire logic [wdp_pkg::ADDR_W-1:0] avs_address,
    input  wire logic                      avs_read,
    input  wire logic                      avs_write,
    input  wire logic [3:0]                avs_byteenable,
    input  wire logic [31:0]               avs_writedata,
    output logic [31:0]                    avs_readdata,
    output logic                           avs_waitrequest,
    // Watchdog oscillator pin and fuses.
    input  wire logic                      wdt_rc_osc,
    input  wire logic [wdp_pkg::CFG_W-1:0] config_word,
    // Core instruction strobes.
    input  wire logic                      watchdog_clear_instruction,
    input  wire logic                      sleep_instruction,
    // Timer0 side of the shared scaler.
    input  wire logic                      tmr0_tick,
    output logic                           tmr0_scaled_tick,
    // Results.
    output logic                           wdt_reset_req,
    output logic                           wdt_wake,
    output logic                           sleeping,
    output logic                           watchdog_expiry_flag,
    output logic                           irq
);

    logic                                  rc_s1_q;
    logic                                  rc_s2_q;
    logic                                  rc_s3_q;
    logic                                  rc_rise;
    logic [wdp_pkg::CFG_W-1:0]             cfg_q;
    logic [wdp_pkg::OPT_W-1:0]             opt_q;
    logic [wdp_pkg::EV_W-1:0]              stat_q;
    logic [wdp_pkg::EV_W-1:0]              stat_d;
    logic [wdp_pkg::EV_W-1:0]              mask_q;
    logic [BASE_W-1:0]                     base_q;
    logic                                  base_ovf;
    logic                                  base_ovf_q;
    logic                                  wd_en;
    logic                                  wd_clear;
    logic                                  scaler_assignment_select;
    logic [wdp_pkg::PS_W-1:0]              ratio;
    logic [wdp_pkg::SHIFT_W-1:0]           shift;
    logic                                  sc_in;
    logic                                  sc_out;
    logic                                  sc_clr;
    logic                                  expiry;
    wdp_pkg::wdp_mode_t                    mode_q;
    logic                                  to_q;
    logic                                  rst_q;
    logic                                  wake_q;
    logic                                  ack_q;
    logic                                  req;
    logic                                  acc;
    logic [wdp_pkg::ADDR_W-1:0]            idx;
    logic                                  hit_opt;
    logic                                  hit_cfg;
    logic                                  hit_stat;
    logic                                  hit_mask;
    logic                                  hit_state;
    logic                                  wr_opt;
    logic                                  wr_mask;
    logic                                  rd_stat;
    logic [31:0]                           rdata_d;
    logic [31:0]                           rdata_q;

    // The RC oscillator is asynchronous, so two flops come before the edge detector.
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            rc_s1_q <= 1'b0;
            rc_s2_q <= 1'b0;
            rc_s3_q <= 1'b0;
        end else begin
            rc_s1_q <= wdt_rc_osc;
            rc_s2_q <= rc_s1_q;
            rc_s3_q <= rc_s2_q;
        end
    end

    assign rc_rise = rc_s2_q && !rc_s3_q; // R1

    // The fuse word is static; it is captured while reset is held.
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            cfg_q <= config_word;
        end
    end

    // Decoding of option and fuse fields.
    assign wd_en    = cfg_q[wdp_pkg::CFG_WATCHDOG_ENABLE_FUSE_BIT]; // R6
    assign scaler_assignment_select      = opt_q[wdp_pkg::OPT_PSA_BIT]; // R10
    assign ratio    = opt_q[wdp_pkg::OPT_PS_LSB +: wdp_pkg::PS_W];
    assign wd_clear = watchdog_clear_instruction || sleep_instruction; // R8

    // Base counter; it runs whatever the mode, since core_clk stands in for the always-on clock.
    assign base_ovf = wd_en && rc_rise && (base_q == '1);
    always_ff @(posedge core_clk) begin
        if (!resetn || !wd_en || wd_clear) begin // R6 R8
            base_q     <= '0;
            base_ovf_q <= 1'b0;
        end else begin
            base_q     <= rc_rise ? base_q + BASE_W'(1) : base_q; // R2
            base_ovf_q <= base_ovf;
        end
    end

    // Shared scaler: Timer0 divides by two to ratio plus one, the watchdog by two to ratio.
    assign sc_in  = scaler_assignment_select ? base_ovf : tmr0_tick; // R7
    assign shift  = scaler_assignment_select ? wdp_pkg::SHIFT_W'(ratio)
                        : wdp_pkg::SHIFT_W'(ratio) + wdp_pkg::SHIFT_W'(1); // R10
    assign sc_clr = scaler_assignment_select && wd_clear; // R8 R9

    wdp_scaler #(
        .CNT_W    (SCALE_W)
    ) u_scaler (
        .core_clk (core_clk),
        .resetn   (resetn),
        .clr      (sc_clr),
        .shift    (shift),
        .tick_in  (sc_in),
        .tick_out (sc_out)
    );

    // Expiry comes from the scaler when assigned, otherwise straight from the base counter.
    assign expiry           = wd_en && !wd_clear && (scaler_assignment_select ? sc_out : base_ovf_q); // R7
    assign tmr0_scaled_tick = !scaler_assignment_select && sc_out;

    // Sleep mode; an expiry while asleep wakes rather than resets.
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            mode_q <= wdp_pkg::WDP_RUN;
            rst_q  <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            rst_q  <= 1'b0;
            wake_q <= 1'b0;
            case (mode_q)
                wdp_pkg::WDP_RUN: begin
                    if (sleep_instruction) begin
                        mode_q <= wdp_pkg::WDP_SLEEP;
                    end else if (expiry) begin
                        rst_q <= 1'b1; // R3
                    end
                end
                wdp_pkg::WDP_SLEEP: begin
                    if (expiry) begin
                        mode_q <= wdp_pkg::WDP_RUN; // R4
                        wake_q <= 1'b1; // R4
                    end
                end
                default: begin
                    mode_q <= wdp_pkg::WDP_RUN;
                end
            endcase
        end
    end

    // Expiry flag: reset and the two instructions set it, an expiry clears it.
    // Expiry is gated off while a clear is present, so a clear in the same cycle wins and sets the flag.
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            to_q <= 1'b1;
        end else if (expiry) begin
            to_q <= 1'b0; // R5
        end else if (wd_clear) begin
            to_q <= 1'b1;
        end
    end

    assign wdt_reset_req        = rst_q;
    assign wdt_wake             = wake_q;
    assign sleeping             = (mode_q == wdp_pkg::WDP_SLEEP);
    assign watchdog_expiry_flag = to_q;

    // Bus decode; each access is answered on its second cycle, mapped or not.
    assign req       = avs_read || avs_write;
    assign acc       = req && ack_q;
    assign idx       = avs_address >> wdp_pkg::IDX_LSB;
    assign hit_opt   = (idx == wdp_pkg::OPT_IDX);
    assign hit_cfg   = (idx == wdp_pkg::CFG_IDX);
    assign hit_stat  = (idx == wdp_pkg::STAT_IDX);
    assign hit_mask  = (idx == wdp_pkg::MASK_IDX);
    assign hit_state = (idx == wdp_pkg::STATE_IDX);
    assign wr_opt    = acc && avs_write && hit_opt && avs_byteenable[0];
    assign wr_mask   = acc && avs_write && hit_mask && avs_byteenable[0];
    assign rd_stat   = acc && avs_read && hit_stat;
    assign avs_waitrequest = req && !ack_q;

    // Read mux; unmapped addresses read as zero.
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (hit_opt) begin
            rdata_d[wdp_pkg::OPT_W-1:0] = opt_q;
        end else if (hit_cfg) begin
            rdata_d[wdp_pkg::CFG_W-1:0] = cfg_q;
        end else if (hit_stat) begin
            rdata_d[wdp_pkg::EV_W-1:0] = stat_q;
        end else if (hit_mask) begin
            rdata_d[wdp_pkg::EV_W-1:0] = mask_q;
        end else if (hit_state) begin
            rdata_d[wdp_pkg::ST_TO]    = to_q;
            rdata_d[wdp_pkg::ST_SLEEP] = sleeping;
            rdata_d[wdp_pkg::ST_EN]    = wd_en;
        end
    end

    // Handshake and read data register.
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q   <= req && !ack_q;
            rdata_q <= rdata_d;
        end
    end

    assign avs_readdata = rdata_q;

    // Option and mask registers; an instruction never touches the assignment bit.
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            opt_q  <= OPT_INIT;
            mask_q <= wdp_pkg::EV_RESET;
        end else begin
            if (wr_opt) begin
                opt_q <= avs_writedata[wdp_pkg::OPT_W-1:0]; // R7 R9
            end
            if (wr_mask) begin
                mask_q <= avs_writedata[wdp_pkg::EV_W-1:0];
            end
        end
    end

    // Sticky events clear on read, but a new event in the same cycle survives.
    // A read clears only the bits it returned, so an event landing after capture is kept.
    always_comb begin
        stat_d = rd_stat ? (stat_q & ~rdata_q[wdp_pkg::EV_W-1:0]) : stat_q;
        stat_d[wdp_pkg::EV_RST]  = stat_d[wdp_pkg::EV_RST] || rst_q;
        stat_d[wdp_pkg::EV_WAKE] = stat_d[wdp_pkg::EV_WAKE] || wake_q;
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            stat_q <= wdp_pkg::EV_RESET;
        end else begin
            stat_q <= stat_d;
        end
    end

    assign irq = |(stat_q & mask_q);

    // Checks.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    AST_RC_EDGE: assert property ( // R1
        $changed(base_q) && $past(wd_en) && !$past(wd_clear) |-> $past(rc_rise))
        else $error("Base counter moved without an oscillator edge.");

    AST_SLEEP_COUNT: assert property ( // R2
        sleeping && wd_en && rc_rise && !wd_clear && base_q != '1
        |=> base_q == $past(base_q) + BASE_W'(1))
        else $error("Base counter stalled during sleep.");

    AST_RESET_REQ: assert property ( // R3
        expiry && !sleeping && !sleep_instruction |=> wdt_reset_req && !wdt_wake)
        else $error("Awake expiry did not request a reset.");

    AST_WAKE: assert property ( // R4
        expiry && sleeping |=> wdt_wake && !sleeping && !wdt_reset_req)
        else $error("Sleep expiry did not wake the device.");

    AST_TO_CLEAR: assert property ( // R5
        expiry |=> !watchdog_expiry_flag)
        else $error("Expiry left the expiry flag set.");

    AST_FUSE_OFF: assert property ( // R6
        !wd_en |-> !expiry && base_q == '0 && !wdt_reset_req && !wdt_wake)
        else $error("Disabled watchdog showed activity.");

    AST_SHARED: assert property ( // R7
        scaler_assignment_select |-> !tmr0_scaled_tick)
        else $error("Timer0 ticked while scaler serves the watchdog.");

    AST_SHARED_SRC: assert property ( // R7
        scaler_assignment_select && !base_ovf |=> !sc_out)
        else $error("Scaler pulsed without a base overflow while serving the watchdog.");

    AST_RESTART: assert property ( // R8
        wd_clear |=> base_q == '0 && !expiry ##1 !wdt_reset_req)
        else $error("Clear did not restart the watchdog.");

    AST_ASSIGN_KEPT: assert property ( // R9
        watchdog_clear_instruction && scaler_assignment_select && !wr_opt |=> opt_q == $past(opt_q) && !sc_out)
        else $error("Clear changed the scaler assignment or leaked a tick.");

    AST_RATIO_ONE: assert property ( // R10
        scaler_assignment_select && ratio == '0 && base_ovf && !wd_clear ##1 !wd_clear |-> expiry)
        else $error("Unity ratio did not pass the base overflow.");

endmodule

// ### tb/tb_watchdog_timer_with_postscaler.sv
`timescale 1ns/1ns
// Self-checking bench for the watchdog with shared postscaler; base counter cut to 4 edges.
module tb_watchdog_timer_with_postscaler;
    // Clock, reset and stimulus.
    logic        core_clk = 1'b0;
    logic        resetn = 1'b0;
    logic [15:0] avs_address = 16'h0000;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [3:0]  avs_byteenable = 4'hF;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic        wdt_rc_osc = 1'b0;
    logic [13:0] config_word = 14'h3FFF;
    logic        clr_ins = 1'b0;
    logic        slp_ins = 1'b0;
    logic        tmr0_tick = 1'b0;
    // Observed outputs.
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        tmr0_scaled_tick;
    logic        wdt_reset_req;
    logic        wdt_wake;
    logic        sleeping;
    logic        expiry_flag;
    logic        irq;
    logic [31:0] q;
    int          error_cnt = 0;
    int          n_compared = 0;
    int          rst_cnt = 0;
    int          wake_cnt = 0;
    int          tmr_cnt = 0;

    // A base width of 2 keeps every expiry within a few dozen cycles.
    wdp_watchdog #(.BASE_W(2), .SCALE_W(8)) dut (
        .core_clk                  (core_clk),
        .resetn                    (resetn),
        .avs_address               (avs_address),
        .avs_read                  (avs_read),
        .avs_write                 (avs_write),
        .avs_byteenable            (avs_byteenable),
        .avs_writedata             (avs_writedata),
        .avs_readdata              (avs_readdata),
        .avs_waitrequest           (avs_waitrequest),
        .wdt_rc_osc                (wdt_rc_osc),
        .config_word               (config_word),
        .watchdog_clear_instruction(clr_ins),
        .sleep_instruction         (slp_ins),
        .tmr0_tick                 (tmr0_tick),
        .tmr0_scaled_tick          (tmr0_scaled_tick),
        .wdt_reset_req             (wdt_reset_req),
        .wdt_wake                  (wdt_wake),
        .sleeping                  (sleeping),
        .watchdog_expiry_flag      (expiry_flag),
        .irq                       (irq)
    );

    // Clock of 10 ns.
    always #5 core_clk = ~core_clk;

    // Pulse counters, so that a lost or doubled pulse shows as a count error.
    always @(posedge core_clk) begin
        if (wdt_reset_req === 1'b1) rst_cnt++;
        if (wdt_wake === 1'b1) wake_cnt++;
        if (tmr0_scaled_tick === 1'b1) tmr_cnt++;
    end

    // Compare one value and count it.
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Verdict; also called by the watchdog process when the run hangs.
    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // One Avalon access; the request holds until waitrequest is sampled low.
    // One idle edge follows, so a following call never reassigns a strobe in the same step.
    task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        avs_byteenable <= be;
        do begin
            @(posedge core_clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask

    // Synchronous reset with a chosen fuse word, held for 5 cycles.
    task automatic do_reset(input logic [13:0] cfg);
        resetn <= 1'b0;
        config_word <= cfg;
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
    endtask

    // Oscillator edges; the tail covers the synchroniser and the expiry pipeline.
    task automatic rc(input int n);
        repeat (n) begin
            wdt_rc_osc <= 1'b1;
            repeat (2) @(posedge core_clk);
            wdt_rc_osc <= 1'b0;
            repeat (2) @(posedge core_clk);
        end
        repeat (10) @(posedge core_clk);
    endtask

    // One-cycle instruction strobe: 1 is sleep, 0 is clear.
    task automatic instr(input bit sl);
        if (sl) slp_ins <= 1'b1;
        else clr_ins <= 1'b1;
        @(posedge core_clk);
        slp_ins <= 1'b0;
        clr_ins <= 1'b0;
        @(posedge core_clk);
    endtask

    // Reset values, read-only places and an unmapped address.
    task automatic t_regs;
        bus(0, 16'h0204, 0, 4'hF); chk("option reset", q, 32'h0000_00FF);
        bus(0, 16'h0248, 0, 4'hF); chk("state reset", q, 32'h0000_0005);
        bus(1, 16'h801C, 32'h0, 4'hF);
        bus(0, 16'h801C, 0, 4'hF); chk("config word", q, 32'h0000_3FFF);
        bus(0, 16'h0400, 0, 4'hF); chk("unmapped", q, 32'h0000_0000);
        bus(1, 16'h0204, 32'h0, 4'h0);
        bus(0, 16'h0204, 0, 4'hF); chk("option be0", q, 32'h0000_00FF);
    endtask

    // Awake expiry without postscaler: reset request, flag low, interrupt.
    task automatic t_awake;
        bus(1, 16'h0244, 32'h1, 4'hF);
        bus(1, 16'h0204, 32'h0, 4'hF);
        instr(0);
        rc(3); chk("no early reset", 32'(rst_cnt), 32'h0);
        rc(1); chk("reset request", 32'(rst_cnt), 32'h1);
        chk("flag after expiry", 32'(expiry_flag), 32'h0);
        chk("irq raised", 32'(irq), 32'h1);
        bus(0, 16'h0240, 0, 4'hF); chk("status reset event", q, 32'h1);
        @(posedge core_clk);
        chk("irq cleared", 32'(irq), 32'h0);
        bus(0, 16'h0240, 0, 4'hF); chk("status empty", q, 32'h0);
    endtask

    // Clear instruction restarts the count and sets the flag again.
    task automatic t_clear;
        instr(0); chk("flag after clear", 32'(expiry_flag), 32'h1);
        rc(3);
        instr(0);
        rc(3); chk("cleared no reset", 32'(rst_cnt), 32'h1);
        rc(1); chk("reset after clear", 32'(rst_cnt), 32'h2);
        bus(0, 16'h0240, 0, 4'hF);
    endtask

    // Postscaler ratio 2 on the watchdog; clear keeps the assignment.
    task automatic t_scaler;
        bus(1, 16'h0204, 32'h09, 4'hF);
        instr(0);
        bus(0, 16'h0204, 0, 4'hF); chk("option kept", q, 32'h09);
        rc(7); chk("scaled no reset", 32'(rst_cnt), 32'h2);
        rc(1); chk("scaled reset", 32'(rst_cnt), 32'h3);
        bus(0, 16'h0240, 0, 4'hF);
    endtask

    // Expiry in sleep wakes the device instead of resetting it.
    task automatic t_sleep;
        bus(1, 16'h0204, 32'h0, 4'hF);
        bus(1, 16'h0244, 32'h3, 4'hF);
        instr(1); chk("sleeping", 32'(sleeping), 32'h1);
        bus(0, 16'h0248, 0, 4'hF); chk("state asleep", q, 32'h7);
        rc(4); chk("wake pulse", 32'(wake_cnt), 32'h1);
        chk("no reset in sleep", 32'(rst_cnt), 32'h3);
        chk("awake again", 32'(sleeping), 32'h0);
        chk("flag after wake", 32'(expiry_flag), 32'h0);
        bus(0, 16'h0240, 0, 4'hF); chk("status wake event", q, 32'h2);
    endtask

    // Timer0 share of the scaler for several option settings.
    task automatic t_tmr(input logic [31:0] opt, input int exp);
        int base;
        bus(1, 16'h0204, opt, 4'hF);
        base = tmr_cnt;
        repeat (8) begin
            tmr0_tick <= 1'b1;
            @(posedge core_clk);
            tmr0_tick <= 1'b0;
            @(posedge core_clk);
        end
        repeat (4) @(posedge core_clk);
        chk("timer0 ticks", 32'(tmr_cnt - base), 32'(exp));
    endtask

    // Unity ratio with the scaler on the watchdog: every base overflow expires.
    task automatic t_unity;
        rc(3); chk("unity early", 32'(rst_cnt), 32'h3);
        rc(1); chk("unity reset", 32'(rst_cnt), 32'h4);
    endtask

    // Fuse cleared: no expiry however many oscillator edges arrive.
    task automatic t_fuse;
        do_reset(14'h3FFB);
        bus(0, 16'h0248, 0, 4'hF); chk("state fuse off", q, 32'h1);
        rc(12); chk("no reset fuse off", 32'(rst_cnt), 32'h4);
        chk("no wake fuse off", 32'(wake_cnt), 32'h1);
    endtask

    // Main sequence.
    initial begin
        do_reset(14'h3FFF);
        t_regs;
        t_awake;
        t_clear;
        t_scaler;
        t_sleep;
        t_tmr(32'h00, 4);
        t_tmr(32'h01, 2);
        t_tmr(32'h08, 0);
        t_unity;
        t_fuse;
        print_verdict;
    end

    // Hang guard, well beyond the few hundred cycles the run needs.
    initial begin
        repeat (20000) @(posedge core_clk);
        error_cnt++;
        print_verdict;
    end
endmodule
